// ### src/ipwdt_device.sv
// Watchdog device end: index/data ports, key lock, countdown
`timescale 1ns/1ns
module ipwdt_device #(
    parameter int MS_CYCLES = ipwdt_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Port link
    ipwdt_if.dev      io,
    // Activity pins, asynchronous
    input  wire logic kbd_act,
    input  wire logic mouse_act,
    // Timeout as reset or interrupt request
    output logic      wdt_timeout
);
    import ipwdt_pkg::*;

    typedef struct packed {
        ipwdt_lock_type lock;
        logic [7:0]     index;
        logic [7:0]     ldsel;
        logic [7:0]     act;
        logic [7:0]     unit;
        logic [7:0]     count;
        logic [7:0]     reload;
        logic           kbd_en;
        logic           mouse_en;
        logic           timeout;
        logic [7:0]     rdata;
        logic           ack;
        logic [2:0]     kbd_s;
        logic [2:0]     ms_s;
    } ipwdt_dev_state_type;

    ipwdt_dev_state_type s_r;
    ipwdt_dev_state_type s_nxt;
    logic                take;
    logic                idx_wr;
    logic                dat_wr;
    logic                dat_rd;
    logic                pre_clear;
    logic                unit_tick;
    logic                strobe;
    logic                expire;

    // Index reaches a watchdog register only with the device selected
    function automatic logic wdt_hit(input logic [7:0] idx,
                                     input logic [7:0] sel,
                                     input logic [7:0] reg_idx);
        wdt_hit = (sel == LDEV_WDT) && (idx == reg_idx);
    endfunction

    ipwdt_prescale #(
        .MS_CYCLES (MS_CYCLES)
    ) i_ipwdt_prescale (
        .clk     (clk),
        .rstn    (rstn),
        .clear   (pre_clear),
        .sel_min (s_r.unit[UNIT_MIN_BIT]),
        .fast    (s_r.unit[UNIT_FAST_BIT]),
        .tick    (unit_tick)
    );

    always_comb begin
        s_nxt     = s_r;
        pre_clear = 1'b0;
        take      = io.io_req && !s_r.ack;
        idx_wr    = take && io.io_wr && (io.io_addr == IDX_PORT);
        dat_wr    = take && io.io_wr && (io.io_addr == DATA_PORT)
                    && (s_r.lock == LK_OPEN);
        dat_rd    = take && !io.io_wr && (io.io_addr == DATA_PORT);
        s_nxt.ack = take;

        // Activity pins: two stages, then a third for edges
        s_nxt.kbd_s = {s_r.kbd_s[1:0], kbd_act};
        s_nxt.ms_s  = {s_r.ms_s[1:0], mouse_act};
        strobe = (s_r.kbd_en && s_r.kbd_s[1] && !s_r.kbd_s[2])
              || (s_r.mouse_en && s_r.ms_s[1] && !s_r.ms_s[2]);

        // Key sequence on the index port
        if (idx_wr) begin
            case (s_r.lock)
                LK_LOCKED: begin
                    s_nxt.lock = (io.io_wdata == KEY_UNLOCK)
                                 ? LK_KEY1 : LK_LOCKED;
                end
                LK_KEY1: begin
                    s_nxt.lock = (io.io_wdata == KEY_UNLOCK)
                                 ? LK_OPEN : LK_LOCKED;
                end
                LK_OPEN: begin
                    if (io.io_wdata == KEY_LOCK) begin
                        s_nxt.lock = LK_LOCKED;
                    end else begin
                        s_nxt.index = io.io_wdata;
                    end
                end
                default: begin
                    s_nxt.lock = LK_LOCKED;
                end
            endcase
        end

        // Data port writes
        if (dat_wr) begin
            if (s_r.index == REG_LDSEL) begin
                s_nxt.ldsel = io.io_wdata;
            end else if (wdt_hit(s_r.index, s_r.ldsel, REG_ACT)) begin
                s_nxt.act = io.io_wdata;
            end else if (wdt_hit(s_r.index, s_r.ldsel, REG_UNIT)) begin
                s_nxt.unit = io.io_wdata;
            end else if (wdt_hit(s_r.index, s_r.ldsel, REG_COUNT)) begin
                s_nxt.count   = io.io_wdata;
                s_nxt.reload  = io.io_wdata;
                s_nxt.timeout = 1'b0;
                pre_clear     = 1'b1;
            end else if (wdt_hit(s_r.index, s_r.ldsel, REG_CTL)) begin
                s_nxt.mouse_en = io.io_wdata[CTL_MOUSE_BIT];
                s_nxt.kbd_en   = io.io_wdata[CTL_KBD_BIT];
                if (io.io_wdata[CTL_FORCE_BIT]) begin
                    s_nxt.timeout = 1'b1;
                end
            end
        end

        // Reads: index port gives index, data port the register
        if (take && !io.io_wr) begin
            s_nxt.rdata = IDLE_RDATA;
            if (io.io_addr == IDX_PORT) begin
                s_nxt.rdata = s_r.index;
            end else if (dat_rd && s_r.lock == LK_OPEN) begin
                if (s_r.index == REG_LDSEL) begin
                    s_nxt.rdata = s_r.ldsel;
                end else if (wdt_hit(s_r.index, s_r.ldsel, REG_ACT)) begin
                    s_nxt.rdata = s_r.act;
                end else if (wdt_hit(s_r.index, s_r.ldsel, REG_UNIT)) begin
                    s_nxt.rdata = s_r.unit;
                end else if (wdt_hit(s_r.index, s_r.ldsel, REG_COUNT)) begin
                    s_nxt.rdata = s_r.count;
                end else if (wdt_hit(s_r.index, s_r.ldsel, REG_CTL)) begin
                    s_nxt.rdata = 8'h00;
                    s_nxt.rdata[CTL_MOUSE_BIT] = s_r.mouse_en;
                    s_nxt.rdata[CTL_KBD_BIT]   = s_r.kbd_en;
                    s_nxt.rdata[CTL_TO_BIT]    = s_r.timeout;
                end
            end
        end

        // Countdown: zero holds, disabled pauses
        expire = unit_tick && s_r.act[ACT_EN_BIT]
                 && (s_r.count == 8'h01);
        if (!s_r.act[ACT_EN_BIT]) begin
            pre_clear = 1'b1;
        end
        if (!(dat_wr && wdt_hit(s_r.index, s_r.ldsel, REG_COUNT))) begin
            if (strobe && s_r.reload != 8'h00) begin
                s_nxt.count = s_r.reload;
                pre_clear   = 1'b1;
            end else if (unit_tick && s_r.act[ACT_EN_BIT]
                         && s_r.count != 8'h00) begin
                s_nxt.count = s_r.count - 8'h01;
            end
        end
        // Expiry wins over a clearing count write in the same cycle
        if (expire) begin
            s_nxt.timeout = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r        <= '0;
            s_r.lock   <= LK_LOCKED;
            s_r.index  <= IDX_RST;
            s_r.ldsel  <= LDSEL_RST;
            s_r.act    <= ACT_RST;
            s_r.unit   <= UNIT_RST;
            s_r.count  <= COUNT_RST;
            s_r.reload <= COUNT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign io.io_ack      = s_r.ack;
    assign io.io_rdata    = s_r.rdata;
    assign io.wdt_timeout = s_r.timeout;
    assign wdt_timeout    = s_r.timeout;
endmodule // ipwdt_device

// ### src/ipwdt_host.sv
// Host end: Wishbone registers driving index/data port cycles
`timescale 1ns/1ns
module ipwdt_host (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wishbone slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt
    output logic             irq,
    // Port link
    ipwdt_if.host            io
);
    import ipwdt_pkg::*;

    typedef struct packed {
        logic                  ack;
        logic [31:0]           dat;
        logic [15:0]           addr;
        logic [1:0]            istat;
        logic [1:0]            imask;
        ipwdt_hstate_type      st;
        logic [1:0][15:0]      qa;
        logic [1:0][7:0]       qd;
        logic                  qw;
        logic [1:0]            left;
        logic [7:0]            rdata;
        logic                  req;
        logic                  to_d;
    } ipwdt_host_state_type;

    ipwdt_host_state_type s_r;
    ipwdt_host_state_type s_nxt;
    logic                 take;
    logic                 wr;
    logic [1:0]           set;
    logic [1:0]           clr;

    always_comb begin
        s_nxt     = s_r;
        take      = wb_cyc_i && wb_stb_i && !s_r.ack;
        wr        = wb_cyc_i && wb_stb_i && s_r.ack && wb_we_i;
        s_nxt.ack = take;
        set       = 2'b00;
        clr       = 2'b00;
        s_nxt.to_d = io.wdt_timeout;
        set[IRQ_TO_BIT] = io.wdt_timeout && !s_r.to_d;

        if (take) begin
            case (wb_adr_i)
                HR_ADDR:  s_nxt.dat = {16'h0, s_r.addr};
                HR_STAT:  s_nxt.dat = {16'h0, s_r.rdata, 7'h0,
                                       s_r.st != HS_IDLE};
                HR_ISTAT: s_nxt.dat = {30'h0, s_r.istat};
                HR_IMASK: s_nxt.dat = {30'h0, s_r.imask};
                default:  s_nxt.dat = 32'h0;
            endcase
        end

        if (wr && wb_adr_i == HR_ADDR) begin
            if (wb_sel_i[0]) s_nxt.addr[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) s_nxt.addr[15:8] = wb_dat_i[15:8];
        end
        if (wr && wb_adr_i == HR_ISTAT && wb_sel_i[0]) begin
            clr = wb_dat_i[1:0];
        end
        if (wr && wb_adr_i == HR_IMASK && wb_sel_i[0]) begin
            s_nxt.imask = wb_dat_i[1:0];
        end
        // Commands are ignored while a sequence runs
        if (wr && wb_adr_i == HR_CMD && s_r.st == HS_IDLE) begin
            s_nxt.st   = HS_ISSUE;
            s_nxt.qw   = 1'b1;
            s_nxt.left = 2'd1;
            s_nxt.qa   = {IDX_PORT, s_r.addr};
            s_nxt.qd   = {8'h00, wb_dat_i[7:0]};
            case (ipwdt_op_type'(wb_dat_i[10:8]))
                OP_READ: s_nxt.qw = 1'b0;
                OP_UNLOCK: begin
                    s_nxt.left = 2'd2;
                    s_nxt.qa   = {IDX_PORT, IDX_PORT};
                    s_nxt.qd   = {KEY_UNLOCK, KEY_UNLOCK};
                end
                OP_LOCK: begin
                    s_nxt.qa = {IDX_PORT, IDX_PORT};
                    s_nxt.qd = {8'h00, KEY_LOCK};
                end
                OP_SELECT: begin
                    s_nxt.left = 2'd2;
                    s_nxt.qa   = {DATA_PORT, IDX_PORT};
                    s_nxt.qd   = {LDEV_WDT, REG_LDSEL};
                end
                default: s_nxt.qw = 1'b1;
            endcase
        end

        case (s_r.st)
            HS_IDLE: s_nxt.req = 1'b0;
            HS_ISSUE: begin
                s_nxt.req = 1'b1;
                s_nxt.st  = HS_WAIT;
            end
            HS_WAIT: begin
                if (io.io_ack) begin
                    s_nxt.req   = 1'b0;
                    s_nxt.rdata = io.io_rdata;
                    s_nxt.qa    = {16'h0, s_r.qa[1]};
                    s_nxt.qd    = {8'h0, s_r.qd[1]};
                    s_nxt.left  = s_r.left - 2'd1;
                    if (s_r.left == 2'd1) begin
                        s_nxt.st = HS_IDLE;
                        set[IRQ_DONE_BIT] = 1'b1;
                    end else begin
                        s_nxt.st = HS_ISSUE;
                    end
                end
            end
            default: s_nxt.st = HS_IDLE;
        endcase
        // Set wins over a same-cycle clear
        s_nxt.istat = (s_r.istat & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r    <= '0;
            s_r.st <= HS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o    = s_r.ack;
    assign wb_dat_o    = s_r.dat;
    assign irq         = |(s_r.istat & s_r.imask);
    assign io.io_req   = s_r.req;
    assign io.io_wr    = s_r.qw;
    assign io.io_addr  = s_r.qa[0];
    assign io.io_wdata = s_r.qd[0];
endmodule // ipwdt_host

// ### src/ipwdt_if.sv
// Byte-wide I/O port link between host bridge and watchdog device
`timescale 1ns/1ns
interface ipwdt_if (
    input wire logic clk
);
    logic        io_req;
    logic        io_wr;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        io_ack;
    logic        wdt_timeout;

    modport dev (
        input  clk,
        input  io_req,
        input  io_wr,
        input  io_addr,
        input  io_wdata,
        output io_rdata,
        output io_ack,
        output wdt_timeout
    );

    modport host (
        input  clk,
        input  io_rdata,
        input  io_ack,
        input  wdt_timeout,
        output io_req,
        output io_wr,
        output io_addr,
        output io_wdata
    );
endinterface

// ### src/ipwdt_pkg.sv
// Shared constants and types of the indexed-port watchdog
package ipwdt_pkg;

    // I/O locations of the index and data ports
    localparam logic [15:0] IDX_PORT      = 16'h002e;
    localparam logic [15:0] DATA_PORT     = 16'h002f;

    // Keys and register indices
    localparam logic [7:0]  KEY_UNLOCK    = 8'h87;
    localparam logic [7:0]  KEY_LOCK      = 8'haa;
    localparam logic [7:0]  REG_LDSEL     = 8'h07;
    localparam logic [7:0]  LDEV_WDT      = 8'h08;
    localparam logic [7:0]  REG_ACT       = 8'h30;
    localparam logic [7:0]  REG_UNIT      = 8'hf5;
    localparam logic [7:0]  REG_COUNT     = 8'hf6;
    localparam logic [7:0]  REG_CTL       = 8'hf7;

    // Field positions
    localparam int          ACT_EN_BIT    = 0;
    localparam int          UNIT_MIN_BIT  = 3;
    localparam int          UNIT_FAST_BIT = 4;
    localparam int          CTL_TO_BIT    = 4;
    localparam int          CTL_FORCE_BIT = 5;
    localparam int          CTL_KBD_BIT   = 6;
    localparam int          CTL_MOUSE_BIT = 7;

    // Values after reset, and the idle read value
    localparam logic [7:0]  LDSEL_RST     = 8'h00;
    localparam logic [7:0]  ACT_RST       = 8'h00;
    localparam logic [7:0]  UNIT_RST      = 8'h00;
    localparam logic [7:0]  COUNT_RST     = 8'h00;
    localparam logic [7:0]  IDX_RST       = 8'h00;
    localparam logic [7:0]  IDLE_RDATA    = 8'hff;

    // Time base: one millisecond from a 4 ns clock
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          MS_TICK_US    = 1000;
    localparam int          MS_CYCLES     =
        MS_TICK_US * 1000 / CLK_PERIOD_PS * 1000;
    localparam logic [16:0] MS_PER_FSEC   = 17'h00001;
    localparam logic [16:0] MS_PER_FMIN   = 17'h0003c;
    localparam logic [16:0] MS_PER_SEC    = 17'h003e8;
    localparam logic [16:0] MS_PER_MIN    = 17'h0ea60;

    // Host register map (byte addresses)
    localparam logic [7:0]  HR_ADDR       = 8'h00;
    localparam logic [7:0]  HR_CMD        = 8'h04;
    localparam logic [7:0]  HR_STAT       = 8'h08;
    localparam logic [7:0]  HR_ISTAT      = 8'h0c;
    localparam logic [7:0]  HR_IMASK      = 8'h10;
    localparam int          IRQ_DONE_BIT  = 0;
    localparam int          IRQ_TO_BIT    = 1;

    typedef enum logic [1:0] {
        LK_LOCKED = 2'b00,
        LK_KEY1   = 2'b01,
        LK_OPEN   = 2'b10
    } ipwdt_lock_type;

    typedef enum logic [2:0] {
        OP_WRITE  = 3'b000,
        OP_READ   = 3'b001,
        OP_UNLOCK = 3'b010,
        OP_LOCK   = 3'b011,
        OP_SELECT = 3'b100
    } ipwdt_op_type;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_ISSUE = 2'b01,
        HS_WAIT  = 2'b10
    } ipwdt_hstate_type;

endpackage

// ### src/ipwdt_prescale.sv
// Prescaler giving one tick per selected counting unit
`timescale 1ns/1ns
module ipwdt_prescale #(
    parameter int MS_CYCLES = ipwdt_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Control
    input  wire logic clear,
    input  wire logic sel_min,
    input  wire logic fast,
    // Unit tick
    output logic      tick
);
    import ipwdt_pkg::*;

    typedef struct packed {
        logic [31:0] cyc;
        logic [16:0] ms;
    } ipwdt_pre_state_type;

    ipwdt_pre_state_type s_r;
    ipwdt_pre_state_type s_nxt;
    logic                ms_tick;
    logic [16:0]         limit;

    // Milliseconds per counting unit
    function automatic logic [16:0] unit_ms(input logic mn,
                                            input logic fs);
        if (fs) begin
            unit_ms = mn ? MS_PER_FMIN : MS_PER_FSEC;
        end else begin
            unit_ms = mn ? MS_PER_MIN : MS_PER_SEC;
        end
    endfunction

    always_comb begin
        limit   = unit_ms(sel_min, fast);
        ms_tick = (s_r.cyc == 32'(MS_CYCLES - 1));
        // At or past the limit, so a unit change mid-count cannot stall
        tick    = ms_tick && (s_r.ms >= limit - 17'h00001);
        s_nxt   = s_r;
        if (clear) begin
            s_nxt.cyc = 32'h0;
            s_nxt.ms  = 17'h0;
        end else if (ms_tick) begin
            s_nxt.cyc = 32'h0;
            s_nxt.ms  = tick ? 17'h0 : s_r.ms + 17'h00001;
        end else begin
            s_nxt.cyc = s_r.cyc + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // ipwdt_prescale

// ### tb/ipwdt_checker.sv
// Assertions on the port link between host and device ends
`timescale 1ns/1ns
module ipwdt_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Port link
    input wire logic        io_req,
    input wire logic        io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_ack,
    input wire logic        wdt_timeout
);
    import ipwdt_pkg::*;

    logic [1:0] key_r;
    logic [7:0] idx_r;
    logic [7:0] sel_r;
    wire logic  ack_wr  = io_ack && io_wr;
    wire logic  ack_rd  = io_ack && !io_wr;
    wire logic  at_idx  = io_addr == IDX_PORT;
    wire logic  at_dat  = io_addr == DATA_PORT;
    wire logic  is_open = key_r == 2'h2;

    // Shadow of key state, index and device select
    always_ff @(posedge clk) begin
        if (!rstn) begin
            key_r <= 2'h0;
            idx_r <= 8'h00;
            sel_r <= 8'h00;
        end else if (ack_wr && at_idx) begin
            if (is_open && io_wdata == KEY_LOCK) begin
                key_r <= 2'h0;
            end else if (is_open) begin
                idx_r <= io_wdata;
            end else begin
                key_r <= (io_wdata == KEY_UNLOCK) ? key_r + 2'h1 : 2'h0;
            end
        end else if (ack_wr && at_dat && is_open && idx_r == REG_LDSEL) begin
            sel_r <= io_wdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence taken_s;
        io_req && !io_ack;
    endsequence
    sequence answer_s;
        io_ack ##1 !io_ack;
    endsequence

    ack_timing_a: assert property (taken_s |=> answer_s)
        else $error("link answer not one pulse after request");
    ack_cause_a: assert property (io_ack |-> $past(io_req))
        else $error("link answer without request");
    locked_read_a: assert property (
        ack_rd && at_dat && !is_open |-> io_rdata == 8'hff)
        else $error("locked data read not idle value");
    idx_read_a: assert property (
        ack_rd && at_idx && is_open |-> io_rdata == idx_r)
        else $error("index read differs from stored index");
    other_read_a: assert property (
        ack_rd && !at_idx && !at_dat |-> io_rdata == 8'hff)
        else $error("foreign address read not idle value");
    force_to_a: assert property (
        ack_wr && at_dat && is_open && sel_r == LDEV_WDT && idx_r == REG_CTL
        && io_wdata[CTL_FORCE_BIT] |-> ##[0:2] wdt_timeout)
        else $error("forced timeout not raised");
    to_clear_a: assert property ($fell(wdt_timeout) |->
        $past(ack_wr && at_dat) || (ack_wr && at_dat))
        else $error("timeout dropped without data write");
    rdata_hold_a: assert property ($changed(io_rdata) |-> ack_rd)
        else $error("read data moved outside a read");
endmodule // ipwdt_checker

// ### tb/ipwdt_test.sv
// Bench for host and device ends of the indexed-port watchdog
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module ipwdt_test;
    import ipwdt_pkg::*;
    localparam int MC = 16;
    logic        clk = 0;
    logic        rstn = 0;
    logic [7:0]  wb_adr = '0;
    logic [31:0] wb_dat = '0;
    logic        wb_we = 0;
    logic        wb_cyc = 0;
    logic        wb_stb = 0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        irq;
    logic        kbd = 0;
    logic        mouse = 0;
    logic        wdt_to;
    int          err_count = 0;
    int          checks = 0;
    int          n;
    logic [7:0]  v;
    logic [31:0] q;
    logic [7:0]  regs [4] = '{REG_ACT, REG_UNIT, REG_COUNT, REG_CTL};

    always #2 clk = ~clk;

    ipwdt_if i_ipwdt_if (.clk(clk));
    ipwdt_host i_ipwdt_host (.clk(clk), .rstn(rstn), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_we_i(wb_we), .wb_sel_i(4'hf),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .irq(irq), .io(i_ipwdt_if.host));
    ipwdt_device #(.MS_CYCLES(MC)) i_ipwdt_device (.clk(clk), .rstn(rstn),
        .io(i_ipwdt_if.dev), .kbd_act(kbd), .mouse_act(mouse),
        .wdt_timeout(wdt_to));
    ipwdt_checker i_ipwdt_checker (.clk(clk), .rstn(rstn),
        .io_req(i_ipwdt_if.io_req), .io_wr(i_ipwdt_if.io_wr),
        .io_addr(i_ipwdt_if.io_addr), .io_wdata(i_ipwdt_if.io_wdata),
        .io_rdata(i_ipwdt_if.io_rdata), .io_ack(i_ipwdt_if.io_ack),
        .wdt_timeout(i_ipwdt_if.wdt_timeout));

    task results;
        $display("err_count=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One classic Wishbone cycle, held until ack is sampled at a rising edge
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        wb_adr <= a;
        wb_dat <= d;
        wb_we  <= we;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (k >= 50) begin
            err_count++;
            results();
        end
    endtask

    task cmd(input logic [2:0] op, input logic [7:0] d);
        int k;
        wb(1'b1, HR_CMD, {21'h0, op, d});
        k = 0;
        do begin
            wb(1'b0, HR_STAT, 32'h0);
            k++;
        end while (q[0] !== 1'b0 && k < 20);
        v = q[15:8];
        `CHK(q[0], 1'b0)
        if (q[0] !== 1'b0) results();
    endtask

    task port(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
        wb(1'b1, HR_ADDR, {16'h0, a});
        cmd(op, d);
    endtask

    task dwr(input logic [7:0] i, input logic [7:0] d);
        port(OP_WRITE, IDX_PORT, i);
        port(OP_WRITE, DATA_PORT, d);
    endtask

    task drd(input logic [7:0] i);
        port(OP_WRITE, IDX_PORT, i);
        port(OP_READ, DATA_PORT, 8'h00);
    endtask

    task wait_to(input int lim);
        n = 0;
        while (wdt_to !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    task t_reset;
        wb(1'b0, HR_STAT, 32'h0);
        `CHK(q, 32'h0)
        wb(1'b0, 8'h40, 32'h0);
        `CHK(q, 32'h0)
        `CHK({irq, wdt_to}, 2'b00)
        cmd(OP_UNLOCK, 8'h00);
        cmd(OP_SELECT, 8'h00);
        foreach (regs[i]) begin
            drd(regs[i]);
            `CHK(v, 8'h00)
        end
        port(OP_READ, IDX_PORT, 8'h00);
        `CHK(v, REG_CTL)
        port(OP_READ, 16'h0080, 8'h00);
        `CHK(v, 8'hff)
    endtask

    task t_lock;
        cmd(OP_LOCK, 8'h00);
        dwr(REG_ACT, 8'h01);
        port(OP_READ, DATA_PORT, 8'h00);
        `CHK(v, 8'hff)
        cmd(OP_UNLOCK, 8'h00);
        drd(REG_ACT);
        `CHK(v, 8'h00)
        dwr(REG_ACT, 8'h01);
        drd(REG_ACT);
        `CHK(v, 8'h01)
        wb(1'b1, HR_IMASK, 32'h2);
        wb(1'b0, HR_ISTAT, 32'h0);
        `CHK(q, 32'h1)
    endtask

    task t_time(input logic [7:0] u, input logic [7:0] c, input int ex);
        dwr(REG_UNIT, u);
        dwr(REG_COUNT, c);
        wait_to(ex + 20);
        `CHK(n + 12 >= ex && n <= ex + 2, 1'b1)
        drd(REG_CTL);
        `CHK(v[CTL_TO_BIT], 1'b1)
        `CHK(irq, 1'b1)
        wb(1'b1, HR_ISTAT, 32'h2);
        @(negedge clk);
        `CHK(irq, 1'b0)
        dwr(REG_COUNT, 8'h00);
        wait_to(100);
        `CHK(wdt_to, 1'b0)
    endtask

    task t_pause;
        dwr(REG_UNIT, 8'h08);
        drd(REG_UNIT);
        dwr(REG_UNIT, v | 8'h10);
        drd(REG_UNIT);
        `CHK(v, 8'h18)
        dwr(REG_COUNT, 8'h01);
        dwr(REG_ACT, 8'h00);
        wait_to(1200);
        `CHK(wdt_to, 1'b0)
        dwr(REG_ACT, 8'h01);
        wait_to(1100);
        `CHK(wdt_to, 1'b1)
        dwr(REG_COUNT, 8'h00);
    endtask

    // Restart by count rewrite (0), keyboard (1) or mouse (2) edge
    task t_restart(input logic [7:0] ctl, input int kind, input logic ok);
        dwr(REG_UNIT, 8'h10);
        dwr(REG_CTL, ctl);
        dwr(REG_COUNT, 8'h03);
        // Rewrite lands well before the first expiry
        repeat (kind == 0 ? 10 : 30) @(negedge clk);
        if (kind == 0)
            dwr(REG_COUNT, 8'h03);
        @(posedge clk);
        kbd   <= (kind == 1);
        mouse <= (kind == 2);
        repeat (3) @(posedge clk);
        kbd   <= 1'b0;
        mouse <= 1'b0;
        wait_to(100);
        `CHK(n >= 28 && n <= 60, ok)
        dwr(REG_COUNT, 8'h00);
        dwr(REG_CTL, 8'h00);
    endtask

    task t_force;
        dwr(REG_CTL, 8'h20);
        wait_to(5);
        `CHK(wdt_to, 1'b1)
        drd(REG_CTL);
        `CHK(v[5:4], 2'b01)
        dwr(REG_COUNT, 8'h00);
        `CHK(wdt_to, 1'b0)
        cmd(OP_LOCK, 8'h00);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_lock();
        t_time(8'h10, 8'h03, 3 * MC);
        t_time(8'h18, 8'h01, 60 * MC);
        t_time(8'h00, 8'h02, 2000 * MC);
        t_pause();
        t_restart(8'h00, 0, 1'b1);
        t_restart(8'h40, 1, 1'b1);
        t_restart(8'h80, 2, 1'b1);
        t_restart(8'h80, 1, 1'b0);
        t_force();
        results();
    end
endmodule // ipwdt_test
